// ==== shared/eeprom_wp_defines.vh ====
// constants of the two-wire eeprom write and protection path
// assumes a 100 MHz system clock and a byte wide memory store outside
`ifndef EEPROM_WP_DEFINES_VH
`define EEPROM_WP_DEFINES_VH

// ****************************************************************
// control byte fields
// ****************************************************************
`define TYPE_ARRAY          4'hA
`define TYPE_PROTECT        4'h6
`define RW_READ             1'h1

// ****************************************************************
// accepted write command kinds
// ****************************************************************
`define CMD_ARRAY           2'h0
`define CMD_PERM_SET        2'h1
`define CMD_REV_SET         2'h2
`define CMD_REV_CLEAR       2'h3

// ****************************************************************
// array layout
// ****************************************************************
`define ADDR_W              8
`define DATA_W              8
`define PAGE_BITS           4
`define LOWER_HALF_BIT      7
`define BITS_PER_BYTE       4'h8

// ****************************************************************
// timing
// ****************************************************************
`define INTERNAL_WRITE_TIME_US 5000
`define CLK_MHZ             100
`define WRITE_CYCLES        (`INTERNAL_WRITE_TIME_US * `CLK_MHZ)
`define TIMER_W             24

// ****************************************************************
// buffering
// ****************************************************************
`define FIFO_DEPTH          32

`endif

// ==== src/byte_fifo.v ====
// synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             mclk,
    input  wire             srst,
    input  wire             clr,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = store[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge mclk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always @(posedge mclk) begin
        if (srst || clr) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // byte_fifo

`default_nettype wire

// ==== src/eeprom_write_protect.v ====
// write path and write protection of a 256 byte two-wire eeprom slave
// assumes scl, sda and the strap pins arrive asynchronously; memory store
// accepts writes on a valid/ready port; flags live here and srst models a blank part
//
// How it works
// - after an acked write address, take a word address and data byte, acking both
// - a stop ending a write starts the timed cycle; bus ignored until it ends
// - protected bytes are still acked, then dropped, and the full cycle still runs
// - after the first data byte up to fifteen more form a 16-byte page
// - every received data byte of a page is acked low
// - after each data byte only the low four address bits count up
// - the in-page address wraps to the page start, later bytes overwrite earlier
// - no ack to a control byte while busy; normal acks once the cycle ends
// - software flags guard the lower half; the protect pin guards everything
// - a type 0110 write sets the permanent flag, pin low, then a write cycle
// - once set the permanent flag stays; 0110 control bytes with high voltage low get no ack
// - byte 01100010 with pins 0,0 and high voltage sets the reversible flag
// - byte 01100110 with pins 0,1 and high voltage clears the reversible flag
// - protect pin high guards all bytes and refuses flag programming
// - protect pin low or floating leaves protection to the two flags
// - pin low, any flag set: only upper half written; no flag: all written
// - permanent status read not acked when set, acked with junk when clear
// - reversible set or status read not acked when that flag is set
// - reversible clear not acked when permanent is set, else clears the flag
// - control byte is type code, three select bits to match, then read bit
// - each byte is acked by pulling data low in the ninth clock
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_wp_defines.vh"

module eeprom_write_protect #(
    parameter [`TIMER_W-1:0] WRITE_CYCLES = `WRITE_CYCLES,
    parameter                FIFO_DEPTH   = `FIFO_DEPTH
) (
    input  wire               mclk,
    input  wire               srst,
    input  wire               scl_in,
    input  wire               sda_in,
    output reg                sda_out,
    output reg                sda_oe_n,
    input  wire               write_protect_pin,
    input  wire               chip_select_bit0,
    input  wire               chip_select_bit1,
    input  wire               chip_select_bit2,
    input  wire               high_voltage_level,
    output reg                mem_wr_valid,
    input  wire               mem_wr_ready,
    output reg  [`ADDR_W-1:0] mem_wr_addr,
    output reg  [`DATA_W-1:0] mem_wr_data,
    output reg                write_busy,
    output reg                permanent_lock_flag,
    output reg                reversible_lock_flag
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_DEV   = 7'h02;
    localparam [6:0] ST_ACK   = 7'h04;
    localparam [6:0] ST_WADDR = 7'h08;
    localparam [6:0] ST_DATA  = 7'h10;
    localparam [6:0] ST_SKIP  = 7'h20;
    localparam [6:0] ST_BUSY  = 7'h40;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    reg  [5:0] meta;
    reg  [5:0] sync;
    reg        scl_d;
    reg        sda_d;
    wire       scl_s = sync[0];
    wire       sda_s = sync[1];
    wire       wp_s  = sync[2];
    wire       cs0_s = sync[3];
    wire       cs1_s = sync[4];
    wire       hv_s  = sync[5];
    reg        cs2_m;
    reg        cs2_s;

    always @(posedge mclk) begin
        if (srst) begin
            meta  <= 6'h03;
            sync  <= 6'h03;
            cs2_m <= 1'b0;
            cs2_s <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            meta  <= {high_voltage_level, chip_select_bit1, chip_select_bit0,
                      write_protect_pin, sda_in, scl_in};
            sync  <= meta;
            cs2_m <= chip_select_bit2;
            cs2_s <= cs2_m;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    wire scl_rise   = scl_s & ~scl_d;
    wire scl_fall   = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

    // ****************************************************************
    // control byte decode
    // ****************************************************************
    reg  [7:0] shreg;
    reg  [3:0] bitcnt;

    wire [2:0] pin_cs   = {cs2_s, cs1_s, cs0_s | hv_s};
    wire       rw_bit   = (shreg[0] == `RW_READ);
    wire       match    = (shreg[3:1] == pin_cs);
    wire       is_array = (shreg[7:4] == `TYPE_ARRAY) & match;
    wire       is_prot  = (shreg[7:4] == `TYPE_PROTECT) & match;
    wire       rev_pins = hv_s & ~cs2_s;
    wire       rev_set  = is_prot & rev_pins & ~cs1_s & ~rw_bit;
    wire       rev_rd   = is_prot & rev_pins & ~cs1_s & rw_bit;
    wire       rev_clr  = is_prot & rev_pins & cs1_s & ~rw_bit;
    wire       perm_op  = is_prot & ~hv_s;
    wire       ack_dev  = is_array
                        | ((rev_set | rev_rd) & ~reversible_lock_flag)
                        | (rev_clr & ~permanent_lock_flag)
                        | (perm_op & ~permanent_lock_flag);
    wire [1:0] dev_cmd  = rev_set ? `CMD_REV_SET :
                          rev_clr ? `CMD_REV_CLEAR :
                          perm_op ? `CMD_PERM_SET : `CMD_ARRAY;

    // ****************************************************************
    // page buffer
    // ****************************************************************
    reg                 fifo_wr;
    reg  [15:0]         fifo_din;
    reg                 fifo_clr;
    wire                fifo_in_ready;
    wire                fifo_out_valid;
    wire [15:0]         fifo_dout;
    wire                drain = write_busy & (~mem_wr_valid | mem_wr_ready);

    byte_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    ($clog2(FIFO_DEPTH))
    ) u_page_buf (
        .mclk      (mclk),
        .srst      (srst),
        .clr       (fifo_clr),
        .in_valid  (fifo_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_din),
        .out_valid (fifo_out_valid),
        .out_ready (drain),
        .out_data  (fifo_dout)
    );

    // ****************************************************************
    // byte protection
    // ****************************************************************
    reg  [`ADDR_W-1:0] addr;
    reg  [1:0]         cmd;
    wire               byte_prot = wp_s
                                 | ((permanent_lock_flag | reversible_lock_flag)
                                    & ~addr[`LOWER_HALF_BIT]);
    wire               data_ack  = (cmd != `CMD_ARRAY) | fifo_in_ready | fifo_wr;

    // ****************************************************************
    // bus engine and write cycle
    // ****************************************************************
    reg [6:0]          state;
    reg [6:0]          after_ack;
    reg                pending;
    reg [`TIMER_W-1:0] timer;

    always @(posedge mclk) begin
        if (srst) begin
            state                <= ST_IDLE;
            after_ack            <= ST_IDLE;
            shreg                <= 8'h00;
            bitcnt               <= 4'h0;
            addr                 <= 8'h00;
            cmd                  <= `CMD_ARRAY;
            pending              <= 1'b0;
            timer                <= {`TIMER_W{1'b0}};
            fifo_wr              <= 1'b0;
            fifo_din             <= 16'h0000;
            fifo_clr             <= 1'b0;
            sda_out              <= 1'b0;
            sda_oe_n             <= 1'b1;
            write_busy           <= 1'b0;
            permanent_lock_flag  <= 1'b0;
            reversible_lock_flag <= 1'b0;
        end else begin
            fifo_wr  <= 1'b0;
            fifo_clr <= 1'b0;
            if (state == ST_BUSY) begin
                // bus fully ignored while the cycle runs
                sda_oe_n <= 1'b1;
                if (timer != {`TIMER_W{1'b0}}) begin
                    timer <= timer - 1'b1;
                end else if (!fifo_out_valid && !mem_wr_valid) begin
                    write_busy <= 1'b0;
                    state      <= ST_IDLE;
                end
            end else if (stop_cond) begin
                sda_oe_n <= 1'b1;
                bitcnt   <= 4'h0;
                pending  <= 1'b0;
                if (pending) begin
                    // every write, protected or not, runs the full time
                    state      <= ST_BUSY;
                    write_busy <= 1'b1;
                    timer      <= WRITE_CYCLES - 1'b1;
                    if (!wp_s) begin
                        case (cmd)
                            `CMD_PERM_SET: begin
                                permanent_lock_flag <= 1'b1;
                            end
                            `CMD_REV_SET: begin
                                reversible_lock_flag <= 1'b1;
                            end
                            `CMD_REV_CLEAR: begin
                                reversible_lock_flag <= 1'b0;
                            end
                            default: begin
                            end
                        endcase
                    end
                end else begin
                    state <= ST_IDLE;
                end
            end else if (start_cond) begin
                sda_oe_n <= 1'b1;
                bitcnt   <= 4'h0;
                state    <= ST_DEV;
                if (pending) begin
                    pending  <= 1'b0;
                    fifo_clr <= 1'b1;
                end
            end else begin
                case (state)
                    ST_DEV, ST_WADDR, ST_DATA: begin
                        if (scl_rise && bitcnt != `BITS_PER_BYTE) begin
                            shreg  <= {shreg[6:0], sda_s};
                            bitcnt <= bitcnt + 1'b1;
                        end else if (scl_fall && bitcnt == `BITS_PER_BYTE) begin
                            state <= ST_ACK;
                            if (state == ST_DEV) begin
                                sda_oe_n  <= ~ack_dev;
                                cmd       <= dev_cmd;
                                after_ack <= (ack_dev && !rw_bit) ? ST_WADDR : ST_SKIP;
                            end else if (state == ST_WADDR) begin
                                sda_oe_n  <= 1'b0;
                                after_ack <= ST_DATA;
                                if (cmd == `CMD_ARRAY) begin
                                    addr <= shreg;
                                end
                            end else begin
                                sda_oe_n  <= ~data_ack;
                                after_ack <= data_ack ? ST_DATA : ST_SKIP;
                                if (data_ack) begin
                                    pending <= 1'b1;
                                    if (cmd == `CMD_ARRAY) begin
                                        addr[`PAGE_BITS-1:0] <= addr[`PAGE_BITS-1:0] + 1'b1;
                                        fifo_wr  <= ~byte_prot;
                                        fifo_din <= {addr, shreg};
                                    end
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            bitcnt   <= 4'h0;
                            state    <= after_ack;
                        end
                    end
                    ST_IDLE, ST_SKIP: begin
                        sda_oe_n <= 1'b1;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // memory store port
    // ****************************************************************
    always @(posedge mclk) begin
        if (srst) begin
            mem_wr_valid <= 1'b0;
            mem_wr_addr  <= 8'h00;
            mem_wr_data  <= 8'h00;
        end else if (!mem_wr_valid || mem_wr_ready) begin
            mem_wr_valid <= drain & fifo_out_valid;
            mem_wr_addr  <= fifo_dout[15:8];
            mem_wr_data  <= fifo_dout[7:0];
        end
    end

endmodule // eeprom_write_protect

`default_nettype wire

// ==== verification/eeprom_write_protect_monitor.sv ====
// concurrent checks on the ports of the eeprom write and protection block
// assumes one mclk domain with srst synchronous active high
`timescale 1ns/1ps
`default_nettype none

module eeprom_wp_monitor #(
    parameter [23:0] WRITE_CYCLES = 24'd500000
) (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       mem_wr_valid,
    input wire logic       mem_wr_ready,
    input wire logic [7:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic       write_busy,
    input wire logic       permanent_lock_flag,
    input wire logic       reversible_lock_flag
);
    // ****************************************************************
    // helper logic
    // ****************************************************************
    logic [23:0] busy_cnt;
    always @(posedge mclk) begin
        if (srst || !write_busy) busy_cnt <= 24'h000000;
        else busy_cnt <= busy_cnt + 24'h000001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_sda_low; sda_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda output level not low");
    property p_ack_stands; $fell(sda_oe_n) |-> !sda_oe_n [*4]; endproperty
    a_ack_stands: assert property (p_ack_stands) else $error("ack slot too short");
    property p_no_ack_busy; write_busy |-> sda_oe_n; endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while busy");
    property p_store_in_cycle; mem_wr_valid |-> write_busy; endproperty
    a_store_in_cycle: assert property (p_store_in_cycle) else $error("store write outside cycle");
    property p_store_hold;
        mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
    endproperty
    a_store_hold: assert property (p_store_hold) else $error("store request dropped");
    property p_lower_guard; mem_wr_valid && !mem_wr_addr[7] |-> !permanent_lock_flag && !reversible_lock_flag;
    endproperty
    a_lower_guard: assert property (p_lower_guard) else $error("lower half written while locked");
    property p_perm_sticks; !$fell(permanent_lock_flag); endproperty
    a_perm_sticks: assert property (p_perm_sticks) else $error("permanent flag cleared");
    property p_rev_clear; $fell(reversible_lock_flag) |-> !permanent_lock_flag; endproperty
    a_rev_clear: assert property (p_rev_clear) else $error("reversible cleared under permanent");
    property p_flag_cycle; $rose(permanent_lock_flag) || $rose(reversible_lock_flag) |-> ##[0:8] write_busy;
    endproperty
    a_flag_cycle: assert property (p_flag_cycle) else $error("flag change without cycle");
    property p_cycle_len; $fell(write_busy) |-> $past(busy_cnt) >= WRITE_CYCLES - 24'd4; endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("write cycle too short");
endmodule // eeprom_wp_monitor

bind eeprom_write_protect eeprom_wp_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .mclk(mclk), .srst(srst), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .write_busy(write_busy), .permanent_lock_flag(permanent_lock_flag),
    .reversible_lock_flag(reversible_lock_flag));
`default_nettype wire

// ==== verification/bus_host_model.sv ====
// two-wire bus host: start, stop and byte transfers with 80 ns bit time
// assumes an open drain data wire with pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none

module bus_host_model (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_wire
);
    // ****************************************************************
    // bus primitives
    // ****************************************************************
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task start_cond;
        sda_drv <= 1'b1;
        #20 scl <= 1'b1;
        #40 sda_drv <= 1'b0;
        #40 scl <= 1'b0;
        #20;
    endtask
    task stop_cond;
        sda_drv <= 1'b0;
        #20 scl <= 1'b1;
        #40 sda_drv <= 1'b1;
        #40;
    endtask
    task send_byte(input logic [7:0] b, output logic ack);
        integer i;
        for (i = 7; i >= 0; i--) begin
            sda_drv <= b[i];
            #20 scl <= 1'b1;
            #40 scl <= 1'b0;
            #20;
        end
        sda_drv <= 1'b1;
        #20 scl <= 1'b1;
        #35 ack = (sda_wire === 1'b0);
        #5 scl <= 1'b0;
        #20;
    endtask
endmodule // bus_host_model
`default_nettype wire

// ==== verification/eeprom_write_protect_tb.sv ====
// self-checking bench for the eeprom write and protection block
// assumes bus_host_model as bus host and a stalling byte store modelled here
`timescale 1ns/1ps
`default_nettype none

module eeprom_write_protect_tb;
    logic        mclk = 1'b0, srst = 1'b1, wp = 1'b0, hv = 1'b0, mem_wr_ready = 1'b0;
    logic [2:0]  cs = 3'h0;
    logic [1:0]  stall = 2'h0;
    logic [15:0] got_q[$], exp_q[$];
    integer      failures = 0, n_checks = 0, i;
    logic        ack_bit;
    wire         scl, host_sda, sda_out, sda_oe_n, mem_wr_valid, write_busy, perm, rev;
    wire [7:0]   mem_wr_addr, mem_wr_data;
    wire         sda_w = host_sda & sda_oe_n;
    always #5 mclk = ~mclk;
    bus_host_model host (.scl(scl), .sda_drv(host_sda), .sda_wire(sda_w));
    eeprom_write_protect #(.WRITE_CYCLES(24'd200), .FIFO_DEPTH(32)) dut (
        .mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .write_protect_pin(wp), .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
        .chip_select_bit2(cs[2]), .high_voltage_level(hv), .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .write_busy(write_busy), .permanent_lock_flag(perm), .reversible_lock_flag(rev));
    // ****************************************************************
    // byte store with stalls
    // ****************************************************************
    always @(posedge mclk) begin
        stall <= stall + 2'h1;
        mem_wr_ready <= (stall != 2'h3);
        if (mem_wr_valid && mem_wr_ready) got_q.push_back({mem_wr_addr, mem_wr_data});
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task pins(input logic [2:0] c, input logic h, input logic w);
        @(posedge mclk);
        cs <= c;
        hv <= h;
        wp <= w;
        repeat (5) @(posedge mclk);
    endtask
    task cmd(input logic [7:0] ctrl, input logic [7:0] addr, input integer n, input logic [7:0] d0,
             input logic exp_ack);
        integer k;
        logic a;
        host.start_cond();
        host.send_byte(ctrl, a);
        check(a === exp_ack, "control byte ack");
        if (a && !ctrl[0]) begin
            host.send_byte(addr, a);
            check(a === 1'b1, "word address ack");
            for (k = 0; k < n; k++) begin
                host.send_byte(8'(d0 + k), a);
                check(a === 1'b1, "data byte ack");
            end
        end
        host.stop_cond();
    endtask
    task run(input logic [7:0] ctrl, input logic [7:0] addr, input integer n, input logic [7:0] d0);
        integer k;
        cmd(ctrl, addr, n, d0, 1'b1);
        repeat (4) @(posedge mclk);
        check(write_busy === 1'b1, "cycle not started");
        cmd({4'hA, ctrl[3:1], 1'b1}, 8'h00, 0, 8'h00, 1'b0);
        for (k = 0; k < 2000 && write_busy !== 1'b0; k++) @(posedge mclk);
        check(write_busy === 1'b0, "cycle not ended");
        cmd({4'hA, ctrl[3:1], 1'b1}, 8'h00, 0, 8'h00, 1'b1);
    endtask
    task cmp_log;
        integer k;
        check(got_q.size() == exp_q.size(), "store write count");
        for (k = 0; k < exp_q.size() && k < got_q.size(); k++) check(got_q[k] === exp_q[k], "store entry");
        got_q.delete();
        exp_q.delete();
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        repeat (5) @(posedge mclk);
        check(perm === 1'b0 && rev === 1'b0 && write_busy === 1'b0, "reset state");
        check(sda_oe_n === 1'b1 && mem_wr_valid === 1'b0, "reset outputs");
        cmd(8'hA2, 8'h00, 0, 8'h00, 1'b0);
        run(8'hA0, 8'h10, 1, 8'h5A);
        exp_q.push_back(16'h105A);
        cmp_log();
        run(8'hA0, 8'h8E, 18, 8'h30);
        for (i = 0; i < 18; i++) exp_q.push_back({4'h8, 4'(4'hE + i), 8'(8'h30 + i)});
        cmp_log();
        pins(3'h1, 1'b1, 1'b0);
        cmd(8'h63, 8'h00, 0, 8'h00, 1'b1);
        run(8'h62, 8'h00, 1, 8'h00);
        check(rev === 1'b1 && perm === 1'b0, "reversible flag not set");
        cmd(8'h62, 8'h00, 1, 8'h00, 1'b0);
        cmd(8'h63, 8'h00, 0, 8'h00, 1'b0);
        pins(3'h0, 1'b0, 1'b0);
        run(8'hA0, 8'h05, 1, 8'h11);
        run(8'hA0, 8'h85, 1, 8'h22);
        pins(3'h0, 1'b0, 1'b1);
        run(8'hA0, 8'h85, 1, 8'h33);
        exp_q.push_back(16'h8522);
        cmp_log();
        pins(3'h3, 1'b1, 1'b1);
        run(8'h66, 8'h00, 1, 8'h00);
        check(rev === 1'b1, "flag cleared with pin high");
        pins(3'h3, 1'b1, 1'b0);
        run(8'h66, 8'h00, 1, 8'h00);
        check(rev === 1'b0, "reversible flag not cleared");
        pins(3'h0, 1'b0, 1'b1);
        run(8'hA0, 8'h05, 1, 8'h44);
        run(8'h60, 8'h00, 1, 8'h00);
        check(perm === 1'b0, "permanent set with pin high");
        pins(3'h0, 1'b0, 1'b0);
        run(8'hA0, 8'h05, 1, 8'h55);
        cmd(8'h61, 8'h00, 0, 8'h00, 1'b1);
        run(8'h60, 8'h17, 1, 8'hC3);
        check(perm === 1'b1, "permanent flag not set");
        cmd(8'h60, 8'h00, 1, 8'h00, 1'b0);
        cmd(8'h61, 8'h00, 0, 8'h00, 1'b0);
        run(8'hA0, 8'h05, 1, 8'h66);
        pins(3'h3, 1'b1, 1'b0);
        cmd(8'h66, 8'h00, 1, 8'h00, 1'b0);
        check(perm === 1'b1, "permanent flag lost");
        exp_q.push_back(16'h0555);
        cmp_log();
        pins(3'h0, 1'b0, 1'b0);
        host.start_cond();
        host.send_byte(8'hA0, ack_bit);
        host.send_byte(8'h90, ack_bit);
        host.send_byte(8'h77, ack_bit);
        check(ack_bit === 1'b1, "upper half data ack");
        cmd(8'hA1, 8'h00, 0, 8'h00, 1'b1);
        repeat (4) @(posedge mclk);
        check(write_busy === 1'b0, "cycle after repeated start");
        run(8'hA0, 8'h91, 1, 8'h78);
        exp_q.push_back(16'h9178);
        cmp_log();
        end_of_test();
    end
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
endmodule // eeprom_write_protect_tb
`default_nettype wire
